/* src/pir_pkg.sv */
/*
  Shared constants and types for the interrupt request port: wire codes,
  message kinds, handshake states and the user-side register map.
  Assumes a single user clock and an active-low asynchronous reset.
*/
package pir_pkg;
  // Interrupt data width and message-data width
  localparam int DATA_W = 8;
  localparam int MSG_DATA_W = 16;
  localparam int RID_W = 16;
  // Multiple message enable limits
  localparam logic [2:0] MME_SINGLE = 3'h0;
  localparam logic [2:0] MME_MAX = 3'h5;
  // Assert select encoding
  localparam logic INTX_ASSERT = 1'b0;
  localparam logic INTX_DEASSERT = 1'b1;
  // Virtual wire codes
  localparam logic [7:0] WIRE_INTA = 8'h00;
  localparam logic [7:0] WIRE_INTB = 8'h01;
  localparam logic [7:0] WIRE_INTC = 8'h02;
  localparam logic [7:0] WIRE_INTD = 8'h03;
  // Handshake states, Gray from IDLE to SEND to GRANT; the return from GRANT to IDLE flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_GRANT = 2'h3
  } pir_state_t;
  // Message kinds on the transmit side
  typedef enum logic [1:0] {
    MSG_NONE = 2'h0,
    MSG_ASSERT_INTX = 2'h1,
    MSG_DEASSERT_INTX = 2'h2,
    MSG_MSI = 2'h3
  } pir_msg_t;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  // User register map, byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VECT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RPID = 8'h0C;
  // CTRL fields
  localparam int CTRL_START = 0;
  localparam int CTRL_DEASSERT = 1;
  // STAT fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_MSI_EN = 2;
  localparam int STAT_MSIX_EN = 3;
  localparam int STAT_MSIX_FM = 4;
  localparam int STAT_MME_LSB = 5;
  localparam int STAT_DATA_LSB = 8;
  // RPID fields
  localparam int RPID_BUS_LSB = 0;
  localparam int RPID_DEV_LSB = 8;
  localparam int RPID_FUNC_LSB = 13;
  localparam int RPID_PORT_LSB = 16;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : pir_pkg

/* src/pir_if.sv */
/*
  Interface joining the device end and the user-logic end of the interrupt
  request port. Assumes both ends run on the same user clock.
*/
`timescale 1ns/1ps
interface pir_if;
  logic irq_request_n;
  logic intx_assert_select;
  logic [7:0] irq_data_in;
  logic irq_grant_n;
  logic [7:0] msi_data_low_out;
  logic [2:0] multi_msg_enable_out;
  logic msi_enabled_out;
  logic msix_enabled_out;
  logic msix_function_mask_out;
  logic [7:0] rp_bus_num;
  logic [4:0] rp_device_num;
  logic [2:0] rp_function_num;
  logic [7:0] rp_port_num;

  modport dev (
    input irq_request_n, intx_assert_select, irq_data_in,
    input rp_bus_num, rp_device_num, rp_function_num, rp_port_num,
    output irq_grant_n, msi_data_low_out, multi_msg_enable_out,
    output msi_enabled_out, msix_enabled_out, msix_function_mask_out
  );
  modport usr (
    output irq_request_n, intx_assert_select, irq_data_in,
    output rp_bus_num, rp_device_num, rp_function_num, rp_port_num,
    input irq_grant_n, msi_data_low_out, multi_msg_enable_out,
    input msi_enabled_out, msix_enabled_out, msix_function_mask_out
  );
endinterface : pir_if

/* src/pir_msg_compose.sv */
/*
  Composes the message kind and payload for one interrupt request.
  Purely combinational; assumes inputs stay stable while the request stands.
*/
`timescale 1ns/1ps
module pir_msg_compose (
  input wire logic msi_en,
  input wire logic [2:0] mme,
  input wire logic [15:0] msi_msg_data,
  input wire logic assert_select,
  input wire logic [7:0] data_in,
  output pir_pkg::pir_msg_t kind,
  output logic [15:0] payload
);
  wire [7:0] vec_mask;
  wire [15:0] msi_word;
  wire [15:0] wire_word;

  // Low mme bits carry the vector; mme zero gives an empty mask
  assign vec_mask = 8'(8'h01 << mme) - 8'h01;
  assign msi_word = (msi_msg_data & ~{8'h00, vec_mask}) | {8'h00, data_in & vec_mask};
  // Two low code bits pick INTA to INTD
  assign wire_word = {14'h0000, data_in[1:0]};

  always_comb begin
    if (msi_en) begin
      kind = pir_pkg::MSG_MSI;
      payload = msi_word;
    end else begin
      kind = (assert_select == pir_pkg::INTX_ASSERT) ? pir_pkg::MSG_ASSERT_INTX :
             pir_pkg::MSG_DEASSERT_INTX;
      payload = wire_word;
    end
  end
endmodule : pir_msg_compose

/* src/pir_dev.sv */
/*
  Device end of the interrupt request port: takes interrupt requests from
  user logic, hands one message at a time to the transmit path, grants on
  completion and reports MSI and MSI-X state. Assumes the transmit path
  answers tx_valid with tx_ready and that configuration state comes from
  the configuration space on the cfg_ inputs.
*/
`timescale 1ns/1ps
module pir_dev #(
  parameter int DATA_W = pir_pkg::DATA_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  pir_if.dev port,
  input wire logic [15:0] cfg_msi_msg_data,
  input wire logic [2:0] cfg_mme,
  input wire logic cfg_msi_en,
  input wire logic cfg_msix_en,
  input wire logic cfg_msix_fm,
  input wire logic tx_ready,
  output logic tx_valid,
  output pir_pkg::pir_msg_t tx_kind,
  output logic [15:0] tx_payload,
  output logic [15:0] tx_requester_id,
  output logic [7:0] link_cap_port_num
);
  if (DATA_W != 8) begin : g_width_check
    $error("pir_dev: interrupt data must be eight bits wide");
  end

  // Package constants the datapath is built around
  if (pir_pkg::MSG_DATA_W != 16) begin : g_msg_width_check
    $error("pir_dev: message data must be sixteen bits wide");
  end
  if (pir_pkg::RID_W != 16) begin : g_rid_width_check
    $error("pir_dev: requester ID must be sixteen bits wide");
  end
  if (pir_pkg::MME_MAX != 3'h5) begin : g_mme_limit_check
    $error("pir_dev: multiple message enable limit must be 101b");
  end
  if (pir_pkg::WIRE_INTD != 8'h03) begin : g_wire_code_check
    $error("pir_dev: wire codes must fit the two low data bits");
  end

  pir_pkg::pir_state_t state_ff;
  pir_pkg::pir_state_t nxt_state;
  logic grant_n_ff;
  logic tx_valid_ff;
  pir_pkg::pir_msg_t tx_kind_ff;
  logic [15:0] tx_payload_ff;
  logic [15:0] rid_ff;
  logic [7:0] port_num_ff;
  logic [7:0] msi_low_ff;
  logic [2:0] mme_ff;
  logic msi_en_ff;
  logic msix_en_ff;
  logic msix_fm_ff;

  wire request_seen;
  wire send_done;
  wire tx_ready_q;
  wire grant_now;
  wire [2:0] mme_clamped;
  wire [15:0] rid_next;
  pir_pkg::pir_msg_t comp_kind;
  logic [15:0] comp_payload;

  // Request taken only when idle
  assign request_seen = (state_ff == pir_pkg::ST_IDLE) && !port.irq_request_n;
  // Handshake with the transmit path counts only with a message pending
  assign tx_ready_q = tx_ready && tx_valid_ff;
  assign send_done = (state_ff == pir_pkg::ST_SEND) && tx_ready_q;
  // Grant only while the request still stands
  assign grant_now = send_done && !port.irq_request_n;
  // Field holds at most 101b
  assign mme_clamped = (cfg_mme > pir_pkg::MME_MAX) ? pir_pkg::MME_MAX : cfg_mme;
  // Requester ID for internally made TLPs only
  assign rid_next = {port.rp_bus_num, port.rp_device_num, port.rp_function_num};

  // Message kind and payload from the standing request
  pir_msg_compose u_compose (
    .msi_en(msi_en_ff),
    .mme(mme_ff),
    .msi_msg_data(cfg_msi_msg_data),
    .assert_select(port.intx_assert_select),
    .data_in(port.irq_data_in),
    .kind(comp_kind),
    .payload(comp_payload)
  );

  // Next state of the request handshake
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pir_pkg::ST_IDLE: begin
        if (request_seen) begin
          nxt_state = pir_pkg::ST_SEND;
        end
      end
      pir_pkg::ST_SEND: begin
        if (send_done) begin
          nxt_state = pir_pkg::ST_GRANT;
        end
      end
      pir_pkg::ST_GRANT: begin
        nxt_state = pir_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = pir_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= pir_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Grant low one cycle after the message left
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_n_ff <= 1'b1;
    end else begin
      grant_n_ff <= !grant_now;
    end
  end

  // Message held for the transmit path until accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_valid_ff <= 1'b0;
      tx_kind_ff <= pir_pkg::MSG_NONE;
      tx_payload_ff <= pir_pkg::RST_HALF;
    end else if (request_seen) begin
      tx_valid_ff <= 1'b1;
      tx_kind_ff <= comp_kind;
      tx_payload_ff <= comp_payload;
    end else if (send_done) begin
      tx_valid_ff <= 1'b0;
      tx_kind_ff <= pir_pkg::MSG_NONE;
    end
  end

  // Root port identity and link capability port number
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rid_ff <= pir_pkg::RST_HALF;
      port_num_ff <= pir_pkg::RST_BYTE;
    end else begin
      rid_ff <= rid_next;
      port_num_ff <= port.rp_port_num;
    end
  end

  // Capability state mirrored to the user
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msi_low_ff <= pir_pkg::RST_BYTE;
      mme_ff <= pir_pkg::MME_SINGLE;
      msi_en_ff <= 1'b0;
      msix_en_ff <= 1'b0;
      msix_fm_ff <= 1'b0;
    end else begin
      msi_low_ff <= cfg_msi_msg_data[7:0];
      mme_ff <= mme_clamped;
      msi_en_ff <= cfg_msi_en;
      msix_en_ff <= cfg_msix_en;
      msix_fm_ff <= cfg_msix_fm;
    end
  end

  assign port.irq_grant_n = grant_n_ff;
  assign port.msi_data_low_out = msi_low_ff;
  assign port.multi_msg_enable_out = mme_ff;
  assign port.msi_enabled_out = msi_en_ff;
  assign port.msix_enabled_out = msix_en_ff;
  assign port.msix_function_mask_out = msix_fm_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_kind = tx_kind_ff;
  assign tx_payload = tx_payload_ff;
  // Only internal TLPs carry this ID
  assign tx_requester_id = rid_ff;
  assign link_cap_port_num = port_num_ff;
endmodule : pir_dev

/* src/pir_usr.sv */
/*
  User-logic end of the interrupt request port, steered by software over
  AHB-Lite. Assumes a single bus master and zero-wait single word transfers.
*/
`timescale 1ns/1ps
module pir_usr #(
  parameter bit ENDPOINT = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  pir_if.usr port
);
  logic req_n_ff;
  logic sel_ff;
  logic [7:0] data_ff;
  logic [7:0] vect_ff;
  logic [7:0] bus_ff;
  logic [4:0] dev_ff;
  logic [2:0] func_ff;
  logic [7:0] pnum_ff;
  logic done_ff;
  logic wr_ff;
  logic [7:0] waddr_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;

  wire addr_ok;
  wire [7:0] mask;
  wire [7:0] irq_word;
  wire granted;
  wire start;
  wire clear_done;
  wire [31:0] stat_word;
  wire [31:0] rpid_word;
  wire [31:0] rd_mux;

  assign addr_ok = hsel && hready && (htrans == pir_pkg::HTRANS_NONSEQ);
  assign granted = !req_n_ff && !port.irq_grant_n;
  assign start = wr_ff && (waddr_ff == pir_pkg::REG_CTRL) && hwdata[pir_pkg::CTRL_START] && req_n_ff;
  assign clear_done = wr_ff && (waddr_ff == pir_pkg::REG_STAT) && hwdata[pir_pkg::STAT_DONE];
  // Merge data out with vector under the MME mask
  assign mask = 8'(8'h01 << port.multi_msg_enable_out) - 8'h01;
  assign irq_word = port.msi_enabled_out ?
    ((port.msi_data_low_out & ~mask) | (vect_ff & mask)) : vect_ff;
  assign stat_word = {16'h0000, port.msi_data_low_out, port.multi_msg_enable_out,
    port.msix_function_mask_out, port.msix_enabled_out, port.msi_enabled_out, done_ff, !req_n_ff};
  assign rpid_word = {8'h00, pnum_ff, func_ff, dev_ff, bus_ff};
  assign rd_mux = (haddr[7:0] == pir_pkg::REG_CTRL) ? {30'h0, sel_ff, 1'b0} :
                  (haddr[7:0] == pir_pkg::REG_VECT) ? {24'h0, vect_ff} :
                  (haddr[7:0] == pir_pkg::REG_STAT) ? stat_word :
                  (haddr[7:0] == pir_pkg::REG_RPID) ? rpid_word : 32'h0000_0000;

  // Bus phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      waddr_ff <= pir_pkg::RST_BYTE;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
    end else begin
      wr_ff <= addr_ok && hwrite;
      waddr_ff <= haddr[7:0];
      rdata_ff <= (addr_ok && !hwrite) ? rd_mux : 32'h0000_0000;
      ready_ff <= 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vect_ff <= pir_pkg::WIRE_INTA;
      bus_ff <= pir_pkg::RST_BYTE;
      dev_ff <= 5'h00;
      func_ff <= 3'h0;
      pnum_ff <= pir_pkg::RST_BYTE;
    end else if (wr_ff && (waddr_ff == pir_pkg::REG_VECT)) begin
      vect_ff <= hwdata[7:0];
    end else if (wr_ff && (waddr_ff == pir_pkg::REG_RPID) && !ENDPOINT) begin
      bus_ff <= hwdata[pir_pkg::RPID_BUS_LSB +: 8];
      dev_ff <= hwdata[pir_pkg::RPID_DEV_LSB +: 5];
      func_ff <= hwdata[pir_pkg::RPID_FUNC_LSB +: 3];
      pnum_ff <= hwdata[pir_pkg::RPID_PORT_LSB +: 8];
    end
  end

  // Request held with select and data until grant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_n_ff <= 1'b1;
      sel_ff <= pir_pkg::INTX_ASSERT;
      data_ff <= pir_pkg::RST_BYTE;
    end else if (start) begin
      req_n_ff <= 1'b0;
      sel_ff <= hwdata[pir_pkg::CTRL_DEASSERT];
      data_ff <= irq_word;
    end else if (granted) begin
      req_n_ff <= 1'b1;
    end
  end

  // Done sticky; a grant beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_ff <= 1'b0;
    end else if (granted) begin
      done_ff <= 1'b1;
    end else if (clear_done) begin
      done_ff <= 1'b0;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp = pir_pkg::HRESP_OKAY;
  assign port.irq_request_n = req_n_ff;
  assign port.intx_assert_select = sel_ff;
  assign port.irq_data_in = data_ff;
  // Endpoint build keeps these at zero
  assign port.rp_bus_num = bus_ff;
  assign port.rp_device_num = dev_ff;
  assign port.rp_function_num = func_ff;
  assign port.rp_port_num = pnum_ff;
endmodule : pir_usr

/* sim/pir_props.sv */
/*
  Checker of the request and grant handshake on the joining interface.
  Assumes one user clock and the interface signals wired by name.
*/
`timescale 1ns/1ps
module pir_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_request_n,
  input wire logic intx_assert_select,
  input wire logic [7:0] irq_data_in,
  input wire logic irq_grant_n,
  input wire logic [2:0] multi_msg_enable_out
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_grant_pulse;
    !irq_grant_n |=> irq_grant_n;
  endproperty
  a_grant_pulse: assert property (p_grant_pulse)
    else $error("grant wider than one cycle");
  property p_grant_with_req;
    !irq_grant_n |-> !irq_request_n;
  endproperty
  a_grant_with_req: assert property (p_grant_with_req)
    else $error("grant without request");
  property p_grant_late;
    !irq_grant_n |-> !$past(irq_request_n) && !$past(irq_request_n, 2);
  endproperty
  a_grant_late: assert property (p_grant_late)
    else $error("grant before message sent");
  property p_req_held;
    !irq_request_n && irq_grant_n |=> !irq_request_n;
  endproperty
  a_req_held: assert property (p_req_held)
    else $error("request dropped before grant");
  property p_req_stable;
    !irq_request_n && irq_grant_n |=> $stable(intx_assert_select) && $stable(irq_data_in);
  endproperty
  a_req_stable: assert property (p_req_stable)
    else $error("select or data moved during request");
  property p_mme_range;
    multi_msg_enable_out <= 3'h5;
  endproperty
  a_mme_range: assert property (p_mme_range)
    else $error("multiple message enable above range");
  property p_grant_bound;
    $fell(irq_request_n) |-> ##[2:40] !irq_grant_n;
  endproperty
  a_grant_bound: assert property (p_grant_bound)
    else $error("no grant after request");
  property p_release;
    $rose(irq_request_n) |-> !$past(irq_grant_n);
  endproperty
  a_release: assert property (p_release)
    else $error("request released without grant");
endmodule : pir_props

/* sim/tb.sv */
/*
  Testbench joining both ends of the interrupt request port.
  Assumes a 50 MHz clock and the bus answering as hreadyout says.
*/
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_q, s;
  logic hreadyout, hresp, rdy_q, tx_valid;
  logic tx_ready = 1'b0;
  logic msi_en = 1'b0;
  logic msix_en = 1'b0;
  logic fm = 1'b0;
  logic [2:0] mme = 3'h0;
  logic [2:0] em;
  logic [15:0] msg = 16'h0;
  logic [15:0] m;
  logic [15:0] tx_payload, tx_rid;
  logic [7:0] port_num;
  logic [7:0] wire_tab [4];
  pir_pkg::pir_msg_t tx_kind;
  int miscompares = 0;
  int check_count = 0;
  pir_if port ();
  pir_dev i_pir_dev (.hclk(hclk), .hresetn(hresetn), .port(port),
    .cfg_msi_msg_data(msg), .cfg_mme(mme), .cfg_msi_en(msi_en), .cfg_msix_en(msix_en),
    .cfg_msix_fm(fm), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_kind(tx_kind),
    .tx_payload(tx_payload), .tx_requester_id(tx_rid), .link_cap_port_num(port_num));
  pir_usr #(.ENDPOINT(1'b0)) i_pir_usr (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port(port));
  pir_props i_pir_props (.hclk(hclk), .hresetn(hresetn),
    .irq_request_n(port.irq_request_n), .intx_assert_select(port.intx_assert_select),
    .irq_data_in(port.irq_data_in), .irq_grant_n(port.irq_grant_n),
    .multi_msg_enable_out(port.multi_msg_enable_out));
  initial begin
    forever #10 hclk = ~hclk;
  end
  always @(negedge hclk) begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
  end
  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic hung(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
    end
  endtask : hung
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pir_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (rdy_q !== 1'b1 && n < 50);
    hung(n, 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (rdy_q !== 1'b1 && n < 100);
    r = rd_q;
    hung(n, 100);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic irq(input logic sel, input logic [7:0] v, input pir_pkg::pir_msg_t k,
                     input logic [15:0] p);
    int n;
    logic [31:0] t;
    n = 0;
    wr(pir_pkg::REG_VECT, {24'h0, v});
    wr(pir_pkg::REG_CTRL, {30'h0, sel, 1'b1});
    while (tx_valid !== 1'b1 && n < 20) begin
      @(negedge hclk);
      n++;
    end
    hung(n, 20);
    check(tx_kind, k, "kind");
    check(tx_payload, p, "payload");
    @(posedge hclk);
    rd(pir_pkg::REG_STAT, t);
    check(t[0], 1'b1, "busy");
    check(tx_valid, 1'b1, "valid held");
    tx_ready <= 1'b1;
    while (port.irq_grant_n !== 1'b0 && n < 40) begin
      @(negedge hclk);
      n++;
    end
    hung(n, 40);
    check(port.irq_request_n, 1'b0, "request at grant");
    @(posedge hclk);
    tx_ready <= 1'b0;
    rd(pir_pkg::REG_STAT, t);
    check(t[1:0], 2'b10, "done");
    wr(pir_pkg::REG_STAT, 32'h2);
  endtask : irq
  initial begin
    wire_tab = '{pir_pkg::WIRE_INTA, pir_pkg::WIRE_INTB, pir_pkg::WIRE_INTC,
                 pir_pkg::WIRE_INTD};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 2; i++) begin
      msg <= i ? 16'h345A : 16'h12A5;
      mme <= i ? 3'h3 : 3'h7;
      msi_en <= ~i[0];
      msix_en <= i[0];
      fm <= ~i[0];
      repeat (2) @(posedge hclk);
      em = i ? 3'h3 : pir_pkg::MME_MAX;
      check(port.msi_data_low_out, msg[7:0], "data out");
      check(port.multi_msg_enable_out, em, "mme");
      check(port.msi_enabled_out, msi_en, "msi en");
      check(port.msix_enabled_out, msix_en, "msix en");
      check(port.msix_function_mask_out, fm, "mask");
      rd(pir_pkg::REG_STAT, s);
      check(s, {16'h0, msg[7:0], em, fm, msix_en, msi_en, 2'b00}, "stat");
    end
    $display("status test ended");
    check(port_num, 8'h00, "port num at reset");
    wr(pir_pkg::REG_RPID, 32'h00A76B5C);
    repeat (2) @(posedge hclk);
    check({port.rp_port_num, port.rp_function_num, port.rp_device_num, port.rp_bus_num},
          24'hA76B5C, "rp fields");
    check(tx_rid, {8'h5C, 5'h0B, 3'h3}, "rid");
    check(port_num, 8'hA7, "port num");
    rd(8'h40, s);
    check(s, 32'h0, "unmapped");
    check(hresp, pir_pkg::HRESP_OKAY, "resp");
    $display("root port test ended");
    msi_en <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      irq(c[0], wire_tab[c / 2], c[0] ? pir_pkg::MSG_DEASSERT_INTX : pir_pkg::MSG_ASSERT_INTX,
          {14'h0, wire_tab[c / 2][1:0]});
    end
    $display("legacy test ended");
    msi_en <= 1'b1;
    msg <= 16'hBEEF;
    for (int j = 0; j < 3; j++) begin
      mme <= (j == 0) ? 3'h2 : (j == 1) ? 3'h0 : 3'h5;
      repeat (2) @(posedge hclk);
      m = (16'h1 << mme) - 16'h1;
      irq(1'b1, 8'hE6, pir_pkg::MSG_MSI, (msg & ~m) | (16'h00E6 & m));
    end
    $display("msi test ended");
    close_out();
  end
endmodule : tb
